// ---- shared/timer_pkg.sv ----
package timer_pkg;
  // Register locations in data memory
  localparam logic [7:0] COUNTER_PRELOAD_ADDR = 8'h0D;
  localparam logic [7:0] TIMER_CONTROL_ADDR = 8'h0E;
  // Control field positions
  localparam int PSC_LSB = 0;
  localparam int EDGE_BIT = 3;
  localparam int RUN_BIT = 4;
  localparam int MODE_LSB = 6;
  // Overflow request flag sits at bit 5 of the interrupt control register
  localparam int OVF_FLAG_BIT = 5;
  // Control reset value 00-0 1000; bit 5 is unused and reads zero
  localparam logic [7:0] CONTROL_RESET = 8'h08;
  localparam logic [7:0] CONTROL_WMASK = 8'hDF;
  localparam logic [7:0] COUNT_MAX = 8'hFF;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  // Divider stages behind the internal timer clock
  localparam int PSC_STAGES = 7;

  // Operating modes held in control bits 7:6
  typedef enum logic [1:0] {
    MODE_UNUSED = 2'h0,
    MODE_EVENT = 2'h1,
    MODE_TIMER = 2'h2,
    MODE_PULSE = 2'h3
  } mode_t;

  // Decoded control register
  typedef struct packed {
    mode_t mode;
    logic unused5;
    logic run;
    logic edge_fall;
    logic [2:0] psc;
  } control_t;

  // Data memory access from the core
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } mem_req_t;
endpackage : timer_pkg

// ---- rtl/prescaler.sv ----
// Free running divider; emits a one-cycle tick every 2**sel system clocks
module prescaler #(
  parameter int STAGES = 7
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [2:0] sel,
  output logic tick
);
  logic [STAGES-1:0] div_q;
  logic [STAGES-1:0] mask;

  // Divider chain, cleared on chip reset
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      div_q <= '0;
    end else begin
      div_q <= div_q + 1'b1;
    end
  end

  // Tick when the selected low bits wrap; sel of zero ticks every cycle
  always_comb begin
    mask = STAGES'((1 << sel) - 1);
    tick = ((div_q & mask) == '0);
  end
endmodule : prescaler

// ---- rtl/timer_event_counter_8bit.sv ----
// How it works
// - Eight-bit up-counter clocked by the timer pin or the prescaled clock.
// - Writes go to preload register; reads return live counter value.
// - Event mode counts pin edges; timer mode counts prescaler ticks.
// - Count to FFH, then reload from preload and set overflow flag bit 5.
// - Pulse mode starts on active edge, stops on return, clears run bit.
// - One measurement only; software must set run again for the next.
// - Pulse measurement needs an edge, not merely an active level.
// - Overflow during pulse measurement reloads and requests like other modes.
// - Control bit 4 is the run bit; one enables counting.
// - Run bit clears itself only in pulse mode, else only by software.
// - Counter overflow is offered as a wake-up source from halt.
// - Clearing the overflow enable stops the request reaching service.
// - Writing while stopped also loads the counter directly.
// - Writing while running only updates preload; counter takes it later.
// - Count clock is blocked during a counter read.
// - Control bits 2:0 divide system clock by two to the power n.
// - Control bit 3 picks the active edge; zero is rising.
// - Divided output toggles on every overflow.
// - Control resets to 00-0 1000; warm reset leaves it alone.
// - Control bits 7:6 pick event, timer or pulse mode; 00 idles.
// - Port A bit 3 latch gates divided output onto the pin.
module timer_event_counter_8bit #(
  parameter int WIDTH = 8
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic warm_rst,
  input wire timer_pkg::mem_req_t mem_req,
  output logic [7:0] mem_rdata,
  input wire logic timer_pin,
  input wire logic ovf_flag_clear,
  input wire logic overflow_irq_enable,
  output logic overflow_request_flag,
  output logic irq_request,
  output logic wake_request,
  input wire logic pfd_option,
  input wire logic port_a_bit3,
  output logic divided_frequency_out,
  output logic pa3_pin_out
);
  // Pulse measurement sequencing
  typedef enum logic [2:0] {
    PW_IDLE = 3'b001,
    PW_WAIT = 3'b010,
    PW_MEAS = 3'b100
  } pw_state_t;

  // Register state
  timer_pkg::control_t ctrl_q;
  logic [WIDTH-1:0] preload_q;
  logic [WIDTH-1:0] count_q;
  logic [WIDTH-1:0] count_d;
  logic pin_q;
  logic pfd_q;
  logic flag_q;
  logic [7:0] rdata_q;
  pw_state_t pw_q;
  pw_state_t pw_d;
  logic tick;
  logic rise;
  logic fall;
  logic act_edge;
  logic ret_edge;
  logic adv;
  logic ovf;
  logic wr_cnt;
  logic wr_ctl;
  logic rd_cnt;
  logic pw_done;
  logic pw_armed;
  logic hit_cnt;
  logic hit_ctl;
  logic [7:0] rdata_d;
  timer_pkg::control_t ctrl_wr;
  logic run_clear;
  logic ld_direct;

  // Free-running divider; the first tick after a start may come early
  prescaler #(
    .STAGES(timer_pkg::PSC_STAGES)
  ) u_psc (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .sel(ctrl_q.psc),
    .tick(tick)
  );

  // Address match, shared by reads and writes
  assign hit_cnt = (mem_req.addr == timer_pkg::COUNTER_PRELOAD_ADDR);
  assign hit_ctl = (mem_req.addr == timer_pkg::TIMER_CONTROL_ADDR);

  // Access strobes; other locations are not ours and are ignored
  assign wr_cnt = mem_req.wr && hit_cnt;
  assign wr_ctl = mem_req.wr && hit_ctl;
  assign rd_cnt = mem_req.rd && hit_cnt;

  // Pin history for edge detection; the pin is already synchronous
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      pin_q <= 1'b0;
    end else begin
      pin_q <= timer_pin;
    end
  end

  // Raw transitions; pin_q resets to the idle low level, so no false edge
  assign rise = timer_pin && !pin_q;
  assign fall = !timer_pin && pin_q;

  // Bit 3 low means rising edge is active; the return edge is the other one
  always_comb begin
    if (ctrl_q.edge_fall) begin
      act_edge = fall;
      ret_edge = rise;
    end else begin
      act_edge = rise;
      ret_edge = fall;
    end
  end

  // Pulse measurement only runs while its mode and the run bit are both set
  assign pw_armed = (ctrl_q.mode == timer_pkg::MODE_PULSE) && ctrl_q.run;

  // Pulse measurement state: arm on run, wait for edge, count to return
  always_comb begin
    pw_d = pw_q;
    pw_done = 1'b0;
    case (pw_q)
      PW_IDLE: begin
        // Arm as soon as run is set in pulse mode
        if (pw_armed) begin
          pw_d = PW_WAIT;
        end
      end
      PW_WAIT: begin
        // An input already at the active level does not start a count
        if (!pw_armed) begin
          pw_d = PW_IDLE;
        end else if (act_edge) begin
          pw_d = PW_MEAS;
        end
      end
      PW_MEAS: begin
        // Leaving the mode or clearing run abandons the measurement
        if (!pw_armed) begin
          pw_d = PW_IDLE;
        end else if (ret_edge) begin
          pw_d = PW_IDLE;
          pw_done = 1'b1;
        end
      end
      default: begin
        pw_d = PW_IDLE;
      end
    endcase
  end

  // Measurement state, idle after chip reset
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      pw_q <= PW_IDLE;
    end else begin
      pw_q <= pw_d;
    end
  end

  // Count enable per mode; a counter read in progress blocks the count clock
  always_comb begin
    case (ctrl_q.mode)
      timer_pkg::MODE_EVENT: begin
        adv = ctrl_q.run && act_edge;
      end
      timer_pkg::MODE_TIMER: begin
        adv = ctrl_q.run && tick;
      end
      timer_pkg::MODE_PULSE: begin
        // The cycle of the return edge is not counted
        adv = (pw_q == PW_MEAS) && tick && !pw_done;
      end
      default: begin
        adv = 1'b0;
      end
    endcase
    if (rd_cnt) begin
      adv = 1'b0;
    end
  end

  // Overflow only on a real count step; a blocked cycle never wraps
  assign ovf = adv && (count_q == WIDTH'(timer_pkg::COUNT_MAX));

  // Hardware clears the run bit only when a measurement completes
  assign run_clear = pw_done && (ctrl_q.mode == timer_pkg::MODE_PULSE);

  // A stopped counter takes written data straight away
  assign ld_direct = wr_cnt && !ctrl_q.run;

  // Next counter value
  always_comb begin
    count_d = count_q;
    if (ovf) begin
      count_d = preload_q;
    end else if (adv) begin
      count_d = count_q + 1'b1;
    end
    // A stopped write overrides any count step
    if (ld_direct) begin
      count_d = WIDTH'(mem_req.wdata);
    end
  end

  // Counter holds its value across both resets, as the hardware does
  always_ff @(posedge ref_clk) begin
    count_q <= count_d;
  end

  // Preload register; running writes only land here
  always_ff @(posedge ref_clk) begin
    if (wr_cnt) begin
      preload_q <= WIDTH'(mem_req.wdata);
    end
  end

  // Writable image of the data bus; bit 5 has no storage and stays zero
  assign ctrl_wr = timer_pkg::control_t'(mem_req.wdata
                                         & timer_pkg::CONTROL_WMASK);

  // Control register; warm reset during halt leaves it untouched
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      ctrl_q <= timer_pkg::control_t'(timer_pkg::CONTROL_RESET);
    end else if (warm_rst) begin
      ctrl_q <= ctrl_q;
    end else if (wr_ctl) begin
      ctrl_q <= ctrl_wr;
      // A software write wins over a same-cycle hardware clear
    end else if (run_clear) begin
      ctrl_q.run <= 1'b0;
    end
  end

  // Sticky overflow request; a new overflow wins over a clear
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      flag_q <= 1'b0;
    end else if (ovf) begin
      flag_q <= 1'b1;
    end else if (ovf_flag_clear) begin
      flag_q <= 1'b0;
    end
  end

  // Flag image for the interrupt control register
  assign overflow_request_flag = flag_q;
  // Service is gated by the enable; the flag itself stays visible
  assign irq_request = flag_q && overflow_irq_enable;
  // Wake-up ignores the enable, so a masked overflow still wakes
  assign wake_request = ovf;

  // Divided-frequency output toggles on each overflow
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      pfd_q <= 1'b0;
    end else if (ovf) begin
      pfd_q <= !pfd_q;
    end
  end

  assign divided_frequency_out = pfd_q;
  // Port latch low forces the pin low when the option is on
  always_comb begin
    if (pfd_option) begin
      pa3_pin_out = port_a_bit3 && pfd_q;
    end else begin
      pa3_pin_out = port_a_bit3;
    end
  end

  // Read mux; counter read shows the live count, unmapped reads zero
  always_comb begin
    rdata_d = timer_pkg::BYTE_ZERO;
    if (hit_cnt) begin
      rdata_d = 8'(count_q);
    end else if (hit_ctl) begin
      rdata_d = 8'(ctrl_q) & timer_pkg::CONTROL_WMASK;
    end
  end

  // Registered read data; held until the next read
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      rdata_q <= timer_pkg::BYTE_ZERO;
    end else if (mem_req.rd) begin
      rdata_q <= rdata_d;
    end
  end

  // Read data comes straight from the register
  assign mem_rdata = rdata_q;
endmodule : timer_event_counter_8bit

// ---- verification/timer_checker.sv ----
module timer_checker (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic warm_rst,
  input wire timer_pkg::mem_req_t mem_req,
  input wire logic [7:0] mem_rdata,
  input wire logic timer_pin,
  input wire logic ovf_flag_clear,
  input wire logic overflow_irq_enable,
  input wire logic overflow_request_flag,
  input wire logic irq_request,
  input wire logic wake_request,
  input wire logic pfd_option,
  input wire logic port_a_bit3,
  input wire logic divided_frequency_out,
  input wire logic pa3_pin_out
);
  timeunit 1ns;
  timeprecision 100ps;
  // One clock domain, reset checked separately
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  // Request flag follows overflow, stays until cleared
  a_irq_gated: assert property (
    irq_request == (overflow_request_flag & overflow_irq_enable))
    else $error("irq gate wrong");
  a_flag_on_ovf: assert property (
    wake_request |=> overflow_request_flag) else $error("flag not set");
  a_flag_sticky: assert property (
    overflow_request_flag && !ovf_flag_clear |=> overflow_request_flag)
    else $error("flag dropped");
  a_flag_clear: assert property (
    ovf_flag_clear && !wake_request |=> !overflow_request_flag)
    else $error("flag not cleared");
  a_pfd_toggle: assert property (
    1'h1 |=> divided_frequency_out ==
    ($past(divided_frequency_out) ^ $past(wake_request)))
    else $error("divided output wrong");
  a_pin_route: assert property (
    pa3_pin_out == (pfd_option ? port_a_bit3 & divided_frequency_out
    : port_a_bit3)) else $error("pin route wrong");
  a_reset_clear: assert property (
    $fell(sys_rst) |-> !overflow_request_flag && !divided_frequency_out)
    else $error("not cleared by reset");
  a_unmapped_zero: assert property (
    mem_req.rd && !(mem_req.addr inside {8'h0D, 8'h0E}) |=> mem_rdata == 0)
    else $error("unmapped read not zero");
  c_overflow: cover property (wake_request);
  c_irq: cover property (irq_request);
  c_pfd_pin: cover property (pfd_option && pa3_pin_out);
endmodule : timer_checker

bind timer_event_counter_8bit timer_checker chk_u (.*);

// ---- verification/event_source.sv ----
// Far side: drives the timer pin, idle low between pulses
module event_source (
  input wire logic ref_clk,
  output logic timer_pin
);
  timeunit 1ns;
  timeprecision 100ps;
  initial timer_pin = 1'h0;
  // High for hi cycles then low for lo; changes just after an edge
  task automatic pulse(int hi, int lo);
    @(posedge ref_clk);
    #2 timer_pin = 1'h1;
    repeat (hi) @(posedge ref_clk);
    #2 timer_pin = 1'h0;
    repeat (lo) @(posedge ref_clk);
    #2;
  endtask : pulse
endmodule : event_source

// ---- verification/tb_top.sv ----
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic ref_clk = 1'h0, sys_rst = 1'h1, warm_rst = 1'h0, timer_pin;
  logic ovf_flag_clear = 1'h0, overflow_irq_enable = 1'h0;
  logic pfd_option = 1'h0, port_a_bit3 = 1'h0;
  logic overflow_request_flag, irq_request, wake_request;
  logic divided_frequency_out, pa3_pin_out;
  logic [7:0] mem_rdata, v, p, q;
  timer_pkg::mem_req_t mem_req = '0;
  int errors = 0, check_count = 0, seed = 24;
  time t;
  // 25 ns clock
  always #12.5 ref_clk = ~ref_clk;
  timer_event_counter_8bit dut_u (.*);
  event_source pin_u (.ref_clk(ref_clk), .timer_pin(timer_pin));
  task automatic step(int n = 1);
    repeat (n) @(posedge ref_clk);
    #2;
  endtask : step
  // One register access; read data has landed when this returns
  task automatic acc(logic w, logic [7:0] a, logic [7:0] d);
    mem_req = '{wr: w, rd: !w, addr: a, wdata: d};
    step();
    mem_req = '0;
    step();
  endtask : acc
  task automatic chk(logic [15:0] seen, logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // Bounded wait for the next overflow pulse
  task automatic wait_wake();
    int n = 0;
    do begin
      step();
      n++;
    end while (wake_request !== 1'h1 && n < 2000);
    if (n >= 2000) errors++;
  endtask : wait_wake
  task automatic conclude();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : conclude
  // Watchdog; the whole run needs well under 20k cycles
  initial begin
    repeat (60000) @(posedge ref_clk);
    errors++;
    conclude();
  end
  initial begin
    step(12);
    sys_rst = 1'h0;
    acc(0, 8'h0E, 8'h00);
    chk(mem_rdata, 8'h08);
    acc(0, 8'h0C, 8'h00);
    chk(mem_rdata, 8'h00);
    acc(1, 8'h0E, 8'hFF);
    warm_rst = 1'h1;
    step();
    warm_rst = 1'h0;
    acc(0, 8'h0E, 8'h00);
    chk(mem_rdata, 8'hDF);
    // Mid-run chip reset brings the control default back
    sys_rst = 1'h1;
    step(2);
    sys_rst = 1'h0;
    acc(0, 8'h0E, 8'h00);
    chk(mem_rdata, 8'h08);
    // Every prescale; preload near the top keeps intervals short
    for (int s = 0; s < 8; s++) begin
      p = 8'hF8 | 8'($random(seed) & 3);
      q = 8'hF8 | 8'($random(seed) & 3);
      overflow_irq_enable = $random(seed);
      pfd_option = $random(seed);
      port_a_bit3 = $random(seed);
      acc(1, 8'h0E, 8'h80 | 8'(s));
      acc(1, 8'h0D, p);
      acc(0, 8'h0D, 8'h00);
      chk(mem_rdata, p);
      acc(1, 8'h0E, 8'h90 | 8'(s));
      wait_wake();
      t = $time;
      acc(1, 8'h0D, q);
      wait_wake();
      chk(16'(($time - t) / 25), 16'((256 - p) << s));
      t = $time;
      wait_wake();
      chk(16'(($time - t) / 25), 16'((256 - q) << s));
      step(); // Let the overflow edge pass, or the set would beat the clear
      chk(overflow_request_flag, 1'h1);
      ovf_flag_clear = 1'h1;
      step();
      ovf_flag_clear = 1'h0;
      chk(overflow_request_flag, 1'h0);
      acc(0, 8'h0E, 8'h00);
      chk(mem_rdata, 8'h90 | 8'(s));
    end
    // A counter read freezes the count for its own cycle
    acc(1, 8'h0E, 8'h80);
    acc(1, 8'h0D, 8'h00);
    acc(1, 8'h0E, 8'h90);
    acc(0, 8'h0D, 8'h00);
    chk(mem_rdata, 8'h01);
    acc(0, 8'h0D, 8'h00);
    chk(mem_rdata, 8'h02);
    // Event counting on either edge
    for (int e = 0; e < 2; e++) begin
      v = 8'($random(seed) & 7) + 8'h01;
      acc(1, 8'h0E, 8'h40 | 8'(e << 3));
      acc(1, 8'h0D, 8'h10);
      acc(1, 8'h0E, 8'h50 | 8'(e << 3));
      repeat (v) pin_u.pulse(3, 3);
      step(3);
      acc(1, 8'h0E, 8'h40);
      acc(0, 8'h0D, 8'h00);
      chk(mem_rdata, 8'h10 + v);
    end
    // Pulse width: a level already high must not start it
    acc(1, 8'h0E, 8'hC0);
    acc(1, 8'h0D, 8'h00);
    fork
      pin_u.pulse(12, 4);
    join_none
    step(3);
    acc(1, 8'h0E, 8'hD0);
    step(14);
    acc(0, 8'h0D, 8'h00);
    chk(mem_rdata, 8'h00);
    v = 8'($random(seed) & 15) + 8'h10;
    pin_u.pulse(v, 4);
    acc(0, 8'h0D, 8'h00);
    chk(mem_rdata, v - 8'h01);
    acc(0, 8'h0E, 8'h00);
    chk(mem_rdata, 8'hC0);
    pin_u.pulse(6, 4);
    acc(0, 8'h0D, 8'h00);
    chk(mem_rdata, v - 8'h01);
    // Falling edge selected: the low span between two pulses is measured
    q = 8'($random(seed) & 15) + 8'h08;
    acc(1, 8'h0D, 8'h00);
    acc(1, 8'h0E, 8'hD8);
    pin_u.pulse(3, q);
    pin_u.pulse(3, 4);
    acc(0, 8'h0D, 8'h00);
    chk(mem_rdata, q);
    acc(0, 8'h0E, 8'h00);
    chk(mem_rdata, 8'hC8);
    conclude();
  end
endmodule : tb_top
